// *** fse_host_model.sv ***
`timescale 1ns/1ps
module fse_host_model (
  input  wire logic                core_clk_in,
  input  wire logic                nrst_in,
  input  wire logic                trap_req_n_in,
  input  wire logic [1:0]          ack_delay_in,
  input  wire logic                cc_load_in,
  input  wire fse_pkg::fse_flags_s cc_in,
  output logic                     trap_ack_out,
  output fse_pkg::fse_flags_s      cc_q_out
);
  // ****************************************************************
  // Host side: trap service and condition code copy
  // ****************************************************************
  logic [1:0] wait_q;
  // Delay varies so the held trap is tested for slow service too
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      trap_ack_out <= 1'b0;
      wait_q       <= 2'h0;
      cc_q_out     <= 4'h0;
    end else begin
      if (!trap_req_n_in && !trap_ack_out && wait_q == ack_delay_in) begin
        trap_ack_out <= 1'b1;
        wait_q       <= 2'h0;
      end else begin
        trap_ack_out <= 1'b0;
        wait_q       <= trap_req_n_in ? 2'h0 : wait_q + 2'h1;
      end
      if (cc_load_in) begin
        cc_q_out <= cc_in;
      end
    end
  end
endmodule

// *** fse_pkg.sv ***
package fse_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_EXC_CODE = 4'h1;
  localparam logic [3:0] ADDR_EXC_ADDR = 4'h2;
  localparam logic [3:0] ADDR_VECTOR   = 4'h3;

  // ****************************************************************
  // Status word bit positions
  // ****************************************************************
  localparam int BIT_ERROR     = 15;
  localparam int BIT_IRQ_DIS   = 14;
  localparam int BIT_UV_EN     = 11;
  localparam int BIT_UF_EN     = 10;
  localparam int BIT_OV_EN     = 9;
  localparam int BIT_CV_EN     = 8;
  localparam int BIT_DOUBLE    = 7;
  localparam int BIT_LONG      = 6;
  localparam int BIT_TRUNC     = 5;
  localparam int BIT_MAINT     = 4;
  localparam int BIT_NEG       = 3;
  localparam int BIT_ZERO      = 2;
  localparam int BIT_OVF       = 1;
  localparam int BIT_CARRY     = 0;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [15:0] STATUS_WMASK  = 16'hCFFF;

  // ****************************************************************
  // Formats
  // ****************************************************************
  localparam int SHORT_INT_W   = 16;
  localparam int LONG_INT_W    = 32;
  localparam int SINGLE_W      = 32;
  localparam int DOUBLE_W      = 64;
  localparam int EXP_W         = 8;
  localparam int SINGLE_FRAC_W = 23;
  localparam int DOUBLE_FRAC_W = 55;
  localparam logic [7:0] EXP_BIAS  = 8'h80;
  localparam logic [8:0] EXP_WRAP  = 9'h100;
  localparam logic [15:0] TRAP_VECTOR = 16'h00A4;

  // ****************************************************************
  // Exception codes
  // ****************************************************************
  localparam logic [3:0] EC_NONE    = 4'h0;
  localparam logic [3:0] EC_OPCODE  = 4'h2;
  localparam logic [3:0] EC_DIVZERO = 4'h4;
  localparam logic [3:0] EC_CONVERT = 4'h6;
  localparam logic [3:0] EC_OVER    = 4'h8;
  localparam logic [3:0] EC_UNDER   = 4'hA;
  localparam logic [3:0] EC_UNDEF   = 4'hC;

  typedef struct packed {
    logic opcode_err;
    logic div_zero;
    logic conv_err;
    logic overflow;
    logic underflow;
    logic minus_zero_fetch;
  } fse_events_s;

  typedef struct packed {
    logic carry;
    logic ovf;
    logic zero;
    logic neg;
  } fse_flags_s;

  typedef enum logic {
    FSE_IDLE,
    FSE_TRAP
  } fse_trap_e;

endpackage

// *** fse_properties.sv ***
`timescale 1ns/1ps
module fse_properties (
  input wire logic                 core_clk_in,
  input wire logic                 nrst_in,
  input wire logic [3:0]           reg_addr_in,
  input wire logic                 reg_wr_in,
  input wire logic                 reg_rd_in,
  input wire logic [15:0]          reg_rdata_out,
  input wire fse_pkg::fse_events_s events_in,
  input wire logic                 ccopy_in,
  input wire logic                 host_cc_load_out,
  input wire logic                 host_operand_vld_in,
  input wire logic                 operand_vld_out,
  input wire logic                 result_vld_in,
  input wire logic [63:0]          result_out,
  input wire logic                 result_vld_out,
  input wire logic                 double_precision_select_out,
  input wire logic                 trap_req_n_out,
  input wire logic [15:0]          trap_vector_out,
  input wire logic                 trap_ack_in
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  AST_VECTOR: assert property (trap_vector_out == 16'h00A4)
    else $error("trap vector moved");
  AST_VEC_READ: assert property (reg_rd_in
    && reg_addr_in == 4'h3 |=> reg_rdata_out == 16'h00A4)
    else $error("vector read wrong");
  AST_CC_LOAD: assert property (1'b1
    |=> host_cc_load_out == $past(ccopy_in))
    else $error("copy pulse misplaced");
  AST_OPV: assert property (operand_vld_out
    |-> $past(host_operand_vld_in))
    else $error("operand valid without request");
  AST_RES_VLD: assert property (result_vld_in
    |=> result_vld_out) else $error("result valid lost");
  AST_CONV_CLR: assert property (result_vld_in
    && events_in.conv_err |=> result_out == 64'h0)
    else $error("conversion result not cleared");
  AST_TRAP_HOLD: assert property (!trap_req_n_out
    && !trap_ack_in |=> !trap_req_n_out)
    else $error("trap dropped before ack");
  AST_TRAP_REL: assert property (!trap_req_n_out
    && trap_ack_in && events_in == 6'h00 |=> trap_req_n_out)
    else $error("trap kept after ack");
  AST_TRAP_CAUSE: assert property ($fell(trap_req_n_out)
    |-> $past(events_in) != 6'h00) else $error("trap without event");
  AST_MODE: assert property (!reg_wr_in
    |=> $stable(double_precision_select_out)) else $error("mode moved");
  cover property (!trap_req_n_out && trap_ack_in);
  cover property (ccopy_in);
  cover property (result_vld_in && events_in.underflow);
endmodule

bind fse_top fse_properties fse_properties_inst (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .events_in(events_in), .ccopy_in(ccopy_in),
  .host_cc_load_out(host_cc_load_out),
  .host_operand_vld_in(host_operand_vld_in),
  .operand_vld_out(operand_vld_out), .result_vld_in(result_vld_in),
  .result_out(result_out), .result_vld_out(result_vld_out),
  .double_precision_select_out(double_precision_select_out),
  .trap_req_n_out(trap_req_n_out), .trap_vector_out(trap_vector_out),
  .trap_ack_in(trap_ack_in));

// *** fse_top.sv ***
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module fse_top (
  input  wire logic                   core_clk_in,
  input  wire logic                   nrst_in,
  // Register port
  input  wire logic [3:0]             reg_addr_in,
  input  wire logic [15:0]            reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [15:0]            reg_rdata_out,
  // Events from the execution core
  input  wire fse_pkg::fse_events_s   events_in,
  input  wire logic [15:0]            instr_addr_in,
  input  wire fse_pkg::fse_flags_s    flags_in,
  input  wire logic                   flags_we_in,
  input  wire logic                   ccopy_in,
  // Operand path: host word in, internal two's complement out
  input  wire logic [63:0]            host_operand_in,
  input  wire logic                   host_operand_vld_in,
  output logic      [57:0]            frac_twos_out,
  output logic      [8:0]             exp_unbiased_out,
  output logic                        operand_vld_out,
  // Result fix-up: raw result in, delivered result out
  input  wire logic [63:0]            result_in,
  input  wire logic                   result_vld_in,
  output logic      [63:0]            result_out,
  output logic                        result_vld_out,
  // Mode outputs and host interface
  output logic                        double_precision_select_out,
  output logic                        long_integer_select_out,
  output logic                        truncate_select_out,
  output logic                        maintenance_mode_out,
  output fse_pkg::fse_flags_s         host_cc_out,
  output logic                        host_cc_load_out,
  output logic                        trap_req_n_out,
  output logic      [15:0]            trap_vector_out,
  input  wire logic                   trap_ack_in
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0]         status_q, status_d;
  logic [3:0]          exception_code_reg_q;
  logic [15:0]         exception_address_reg_q;
  fse_pkg::fse_trap_e  trap_q;
  logic [15:0]         rdata_q;

  wire irq_disable              = status_q[fse_pkg::BIT_IRQ_DIS];
  wire undefined_var_irq_enable = status_q[fse_pkg::BIT_UV_EN];
  wire underflow_irq_enable     = status_q[fse_pkg::BIT_UF_EN];
  wire overflow_irq_enable      = status_q[fse_pkg::BIT_OV_EN];
  wire conversion_irq_enable    = status_q[fse_pkg::BIT_CV_EN];
  wire double_precision_select  = status_q[fse_pkg::BIT_DOUBLE];
  wire long_integer_select      = status_q[fse_pkg::BIT_LONG];
  wire truncate_select          = status_q[fse_pkg::BIT_TRUNC];
  wire maintenance_mode         = status_q[fse_pkg::BIT_MAINT];

  // ****************************************************************
  // Exception priority and enables
  // ****************************************************************
  fse_pkg::fse_events_s ev;
  assign ev = events_in;
  wire uv_trap = ev.minus_zero_fetch
                 && undefined_var_irq_enable;
  wire uf_trap = ev.underflow && underflow_irq_enable;
  wire ov_trap = ev.overflow && overflow_irq_enable;
  wire cv_trap = ev.conv_err && conversion_irq_enable;
  // Opcode and divide errors have no own enable
  wire any_exc = !irq_disable && (ev.opcode_err || ev.div_zero
                 || cv_trap || ov_trap || uf_trap || uv_trap);
  // Lowest code wins when causes coincide
  wire [3:0] exc_code =
    ev.opcode_err ? fse_pkg::EC_OPCODE  :
    ev.div_zero   ? fse_pkg::EC_DIVZERO :
    cv_trap       ? fse_pkg::EC_CONVERT :
    ov_trap       ? fse_pkg::EC_OVER    :
    uf_trap       ? fse_pkg::EC_UNDER   :
    uv_trap       ? fse_pkg::EC_UNDEF   : fse_pkg::EC_NONE;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire wr_status = reg_wr_in && (reg_addr_in == fse_pkg::ADDR_STATUS);
  wire [15:0] rd_mux =
    (reg_addr_in == fse_pkg::ADDR_STATUS)   ? status_q :
    (reg_addr_in == fse_pkg::ADDR_EXC_CODE) ? {12'h000,
                                               exception_code_reg_q} :
    (reg_addr_in == fse_pkg::ADDR_EXC_ADDR) ? exception_address_reg_q :
    (reg_addr_in == fse_pkg::ADDR_VECTOR)   ? fse_pkg::TRAP_VECTOR :
                                              16'h0000;

  // Status next value; hardware events win over a same-cycle write
  always_comb begin
    status_d = status_q;
    if (wr_status) begin
      status_d = reg_wdata_in & fse_pkg::STATUS_WMASK;
    end
    if (flags_we_in) begin
      status_d[fse_pkg::BIT_NEG]   = flags_in.neg;
      status_d[fse_pkg::BIT_ZERO]  = flags_in.zero;
      status_d[fse_pkg::BIT_OVF]   = flags_in.ovf;
      status_d[fse_pkg::BIT_CARRY] = flags_in.carry;
    end
    if (ev.conv_err) begin
      status_d[fse_pkg::BIT_CARRY] = 1'b1;
    end
    if (any_exc) begin
      status_d[fse_pkg::BIT_ERROR] = 1'b1;
    end
  end

  // ****************************************************************
  // Operand conversion
  // ****************************************************************
  // Format is picked by the double-precision bit
  wire        op_sign = host_operand_in[63];
  wire [7:0]  op_exp  = host_operand_in[62:55];
  wire [54:0] op_frac = double_precision_select ?
                        host_operand_in[54:0] :
                        {host_operand_in[54:32], 32'h00000000};
  wire        op_zero = (op_exp == 8'h00);
  wire        op_mzero = op_zero && op_sign;
  // Minus zero is treated as plus zero in arithmetic
  wire        eff_sign = op_sign && !op_zero;
  // Hidden one restored for nonzero operands
  wire [56:0] mag = {1'b0, !op_zero, op_frac};
  wire [57:0] mag_x = {1'b0, mag};
  wire [57:0] twos = eff_sign ? 58'(~mag_x + 58'h1) : mag_x;
  // Bias removal keeps a sign bit for negative exponents
  wire [8:0]  exp_true = 9'({1'b0, op_exp}
                            - {1'b0, fse_pkg::EXP_BIAS});

  // ****************************************************************
  // Result fix-up
  // ****************************************************************
  // A conversion error clears the destination outright; integer width
  // trimming stays in the core, which knows the destination size.
  // Wrapped exponent already differs by octal 400 from true value
  wire [63:0] res_fix =
    ev.conv_err ? 64'h0000000000000000 :
    (ev.underflow && !underflow_irq_enable) ?
      64'h0000000000000000 :
    result_in;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      status_q                <= fse_pkg::STATUS_RESET;
      exception_code_reg_q    <= fse_pkg::EC_NONE;
      exception_address_reg_q <= 16'h0000;
      trap_q                  <= fse_pkg::FSE_IDLE;
      rdata_q                 <= 16'h0000;
    end else begin
      status_q <= status_d;
      rdata_q  <= reg_rd_in ? rd_mux : 16'h0000;
      if (any_exc) begin
        exception_code_reg_q    <= exc_code;
        exception_address_reg_q <= instr_addr_in;
      end
      unique case (trap_q)
        fse_pkg::FSE_IDLE: begin
          if (any_exc) begin
            trap_q <= fse_pkg::FSE_TRAP;
          end
        end
        fse_pkg::FSE_TRAP: begin
          if (trap_ack_in && !any_exc) begin
            trap_q <= fse_pkg::FSE_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      frac_twos_out    <= 58'h0;
      exp_unbiased_out <= 9'h000;
      operand_vld_out  <= 1'b0;
      result_out       <= 64'h0;
      result_vld_out   <= 1'b0;
      host_cc_out      <= '0;
      host_cc_load_out <= 1'b0;
      trap_req_n_out   <= 1'b1;
      trap_vector_out  <= fse_pkg::TRAP_VECTOR;
    end else begin
      frac_twos_out    <= twos;
      exp_unbiased_out <= exp_true;
      operand_vld_out  <= host_operand_vld_in && !(op_mzero
                          && undefined_var_irq_enable);
      result_out       <= res_fix;
      result_vld_out   <= result_vld_in;
      host_cc_out      <= {status_q[fse_pkg::BIT_CARRY],
                           status_q[fse_pkg::BIT_OVF],
                           status_q[fse_pkg::BIT_ZERO],
                           status_q[fse_pkg::BIT_NEG]};
      host_cc_load_out <= ccopy_in;
      trap_req_n_out   <= !((trap_q == fse_pkg::FSE_TRAP && !trap_ack_in)
                            || any_exc);
      trap_vector_out  <= fse_pkg::TRAP_VECTOR;
    end
  end

  assign reg_rdata_out               = rdata_q;
  assign double_precision_select_out = double_precision_select;
  assign long_integer_select_out     = long_integer_select;
  assign truncate_select_out         = truncate_select;
  assign maintenance_mode_out        = maintenance_mode;

endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin \
  fails = fails + 1; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
  logic                core_clk_in, nrst_in, reg_wr_in, reg_rd_in, ccopy_in;
  logic                flags_we_in, host_operand_vld_in, result_vld_in;
  logic                trap_ack_in, operand_vld_out, result_vld_out;
  logic                dbl, lng, trn, mnt, cc_load, trap_req_n_out;
  logic [3:0]          reg_addr_in;
  logic [15:0]         reg_wdata_in, instr_addr_in, reg_rdata_out, vec, stat;
  logic [15:0]         rd, ea;
  logic [63:0]         host_operand_in, result_in, result_out, res;
  logic [57:0]         frac_twos;
  logic [8:0]          exp_unb;
  logic [1:0]          ack_delay;
  logic [54:0]         fr;
  logic                tr;
  fse_pkg::fse_events_s events_in;
  fse_pkg::fse_flags_s  flags_in, host_cc, cc_seen;
  integer              seed = 77, fails = 0, tests_run = 0, k, idx, w;

  fse_top fse_top_inst (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .events_in(events_in), .instr_addr_in(instr_addr_in), .flags_in(flags_in),
    .flags_we_in(flags_we_in), .ccopy_in(ccopy_in),
    .host_operand_in(host_operand_in),
    .host_operand_vld_in(host_operand_vld_in),
    .frac_twos_out(frac_twos), .exp_unbiased_out(exp_unb),
    .operand_vld_out(operand_vld_out), .result_in(result_in),
    .result_vld_in(result_vld_in), .result_out(result_out),
    .result_vld_out(result_vld_out), .double_precision_select_out(dbl),
    .long_integer_select_out(lng), .truncate_select_out(trn),
    .maintenance_mode_out(mnt), .host_cc_out(host_cc),
    .host_cc_load_out(cc_load),
    .trap_req_n_out(trap_req_n_out), .trap_vector_out(vec),
    .trap_ack_in(trap_ack_in));
  fse_host_model fse_host_model_inst (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .trap_req_n_in(trap_req_n_out), .ack_delay_in(ack_delay),
    .cc_load_in(cc_load), .cc_in(host_cc), .trap_ack_out(trap_ack_in),
    .cc_q_out(cc_seen));

  // ****************************************************************
  // Bus tasks and expectations
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdx(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1; reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic opnd(input logic [63:0] v);
    @(posedge core_clk_in);
    host_operand_in <= v; host_operand_vld_in <= 1'b1;
    @(posedge core_clk_in);
    host_operand_vld_in <= 1'b0;
    #1;
  endtask
  // Disable bit wins; opcode and divide ignore the per-cause enables
  function automatic logic exp_trap(input logic [15:0] s, input integer i);
    return !s[14] && (i < 2 || s[6 + i]);
  endfunction
  // Hidden one restored, then negated for a minus sign
  function automatic logic [57:0] exp_frac(input logic s,
                                           input logic [54:0] f);
    logic [57:0] m;
    m = {3'b001, f};
    return s ? 58'(-m) : m;
  endfunction
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  initial begin
    #100000 fails = fails + 1;
    final_report();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {nrst_in, reg_wr_in, reg_rd_in, ccopy_in, flags_we_in} = 5'h00;
    {host_operand_vld_in, result_vld_in, ack_delay} = 4'h0;
    reg_addr_in = 4'h0; reg_wdata_in = 16'h0000; instr_addr_in = 16'h0000;
    events_in = 6'h00; flags_in = 4'h0; host_operand_in = 64'h0;
    result_in = 64'h0;
    repeat (16) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    rdx(fse_pkg::ADDR_STATUS, rd); `CHK(rd, 16'h0000)
    rdx(fse_pkg::ADDR_VECTOR, rd); `CHK(rd, 16'h00A4)
    `CHK(vec, 16'h00A4)
    rdx(4'h9, rd); `CHK(rd, 16'h0000)
    wr(fse_pkg::ADDR_STATUS, 16'hFFFF);
    rdx(fse_pkg::ADDR_STATUS, rd); `CHK(rd, 16'hCFFF)
    `CHK({dbl, lng, trn, mnt}, 4'hF)
    wr(fse_pkg::ADDR_STATUS, 16'h0880);
    #1;
    `CHK({dbl, lng, trn, mnt}, 4'h8)
    fr = 55'({$random(seed), $random(seed)});
    opnd({1'b0, 8'h83, fr});
    `CHK(operand_vld_out, 1'b1)
    `CHK(exp_unb, 9'h003)
    `CHK(frac_twos, exp_frac(1'b0, fr))
    fr = 55'({$random(seed), $random(seed)});
    opnd({1'b1, 8'h7F, fr});
    `CHK(exp_unb, 9'h1FF)
    `CHK(frac_twos, exp_frac(1'b1, fr))
    wr(fse_pkg::ADDR_STATUS, 16'h0800);
    fr = 55'({$random(seed), $random(seed)});
    opnd({1'b1, 8'h90, fr});
    `CHK(frac_twos, exp_frac(1'b1, {fr[54:32], 32'h00000000}))
    opnd(64'h8000000000000000);
    `CHK(operand_vld_out, 1'b0)
    `CHK(frac_twos, 58'h0)
    @(posedge core_clk_in);
    flags_in <= 4'($random(seed)); flags_we_in <= 1'b1;
    @(posedge core_clk_in);
    flags_we_in <= 1'b0; ccopy_in <= 1'b1;
    @(posedge core_clk_in);
    ccopy_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1 `CHK(cc_seen, flags_in)
    for (k = 0; k < 30; k++) begin
      idx = k % 6;
      stat = k < 6 ? 16'h0F00 : k < 12 ? 16'h0000 : k < 18 ? 16'h4F00 :
             16'($random(seed)) & 16'h4F00;
      tr = exp_trap(stat, idx);
      ack_delay <= 2'($random(seed));
      res = {$random(seed), $random(seed)};
      ea = 16'($random(seed));
      wr(fse_pkg::ADDR_STATUS, stat);
      @(posedge core_clk_in);
      events_in <= 6'h20 >> idx; instr_addr_in <= ea;
      result_in <= res; result_vld_in <= 1'b1;
      @(posedge core_clk_in);
      events_in <= 6'h00; result_vld_in <= 1'b0;
      #1;
      `CHK(trap_req_n_out, !tr)
      if (idx == 2 || (idx == 4 && !stat[10])) res = 64'h0;
      `CHK(result_out, res)
      rdx(fse_pkg::ADDR_STATUS, rd);
      `CHK(rd[15], tr)
      `CHK(rd[0], idx == 2)
      if (tr) begin
        rdx(fse_pkg::ADDR_EXC_CODE, rd);
        `CHK(rd, 16'(2 * idx + 2))
        rdx(fse_pkg::ADDR_EXC_ADDR, rd); `CHK(rd, ea)
        for (w = 0; w < 20 && trap_req_n_out !== 1'b1; w++) begin
          @(posedge core_clk_in);
          #1;
        end
        `CHK(trap_req_n_out, 1'b1)
      end
    end
    final_report();
  end
endmodule
